// [core/tbc_timer2.sv]
// Third timer: baud generator, clock-out, capture/reload and interrupt enables
// Function
// - Either baud select bit puts the timer in baud generator mode.
// - Baud mode high-byte rollover reloads the full counter from the reload bytes.
// - Serial bit rate is overflow rate divided by sixteen.
// - Baud mode counts every state time; plain timer counts every machine cycle.
// - Baud bit rate equals oscillator over 32 times (65536 minus reload).
// - Baud mode rollover sets no overflow flag and raises no interrupt.
// - Baud mode edge input sets edge flag but never reloads.
// - Clock-out pin carries square wave at oscillator over 4(65536 minus reload).
// - Clock-out pin also serves as general I/O and count input.
// - Clock-out mode rollovers raise no interrupt.
// - Baud and clock-out may run together from shared reload bytes.
// - Timer interrupt request is overflow flag OR edge flag.
// - Hardware never clears the two flags; software clears them.
// - Overflow flag set in the overflow cycle and seen at once.
// - Six interrupt sources, each with its own enable bit.
// - Global enable low blocks all; high defers to individual enables.
// - Enable register layout fixed, bit six reserved, zero disables.
// - Baud select forces auto-reload, ignoring capture select.
// - Counter select high counts falling edges of the count input.
`timescale 1ns/10ps
module tbc_timer2 (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic edge_input_pin_i,
  input wire logic clock_out_pin_i,
  output logic clock_out_pin_o,
  output logic clock_out_pin_oe_o,
  input wire logic ext0_req_i,
  input wire logic timer0_req_i,
  input wire logic ext1_req_i,
  input wire logic timer1_req_i,
  input wire logic serial_req_i,
  output logic [5:0] irq_req_o,
  output logic rx_bit_tick_o,
  output logic tx_bit_tick_o
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  tbc_pkg::tbc_ctrl_type ctrl_r;
  tbc_pkg::tbc_ctrl_type ctrl_nxt;
  tbc_pkg::tbc_aph_type aph_r;
  logic [7:0] mode_r;
  logic [7:0] ie_r;
  logic [7:0] pin_r;
  logic [15:0] count_r;
  logic [15:0] reload_r;
  logic [3:0] baud_div_r;
  logic clk_wave_r;
  logic state_tick;
  logic mach_tick;
  logic cnt_fall;
  logic edge_fall;
  logic baud_mode;
  logic clkout_mode;
  logic inc;
  logic ovf;
  logic edge_ev;
  logic auto_rl;
  logic reload_now;
  logic capture_now;
  logic wr_en;
  logic [7:0] wdata;
  logic [5:0] src;
  // Register read mux
  function automatic logic [7:0] read_reg(input logic [2:0] idx);
    logic [7:0] v;
    v = 8'h00;
    case (idx)
      tbc_pkg::IDX_MAIN_CTRL: v = ctrl_r;
      tbc_pkg::IDX_MODE_CTRL: v = mode_r;
      tbc_pkg::IDX_COUNT_LOW: v = count_r[7:0];
      tbc_pkg::IDX_COUNT_HIGH: v = count_r[15:8];
      tbc_pkg::IDX_RELOAD_LOW: v = reload_r[7:0];
      tbc_pkg::IDX_RELOAD_HIGH: v = reload_r[15:8];
      tbc_pkg::IDX_IRQ_ENABLE: v = ie_r;
      tbc_pkg::IDX_PIN_CTRL: v = {6'h00, clock_out_pin_i, pin_r[tbc_pkg::BIT_PIN_LATCH]};
      default: v = 8'h00;
    endcase
    return v;
  endfunction
  // Software write strobe for one register
  function automatic logic wr_hit(input logic [2:0] idx);
    return wr_en & (aph_r.idx == idx);
  endfunction
  // ----------------------------------------
  // Timing sources
  // ----------------------------------------
  tbc_prescale u_prescale (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .state_tick_o(state_tick),
    .mach_tick_o(mach_tick)
  );
  // External count input shares the clock-out pin
  tbc_fall_detect u_count_edge (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .sample_i(mach_tick),
    .pin_i(clock_out_pin_i),
    .fall_o(cnt_fall)
  );
  tbc_fall_detect u_ext_edge (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .sample_i(mach_tick),
    .pin_i(edge_input_pin_i),
    .fall_o(edge_fall)
  );
  // ----------------------------------------
  // AHB-Lite slave
  // ----------------------------------------
  // Address phase capture; reads take one wait state
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      aph_r <= '0;
      hreadyout_o <= 1'b1;
      hrdata_o <= 32'h0000_0000;
      hresp_o <= 1'b0;
    end
    else
    begin
      if (hready_i)
      begin
        aph_r.act <= hsel_i & (htrans_i == tbc_pkg::HTRANS_NONSEQ) & (hsize_i == tbc_pkg::HSIZE_WORD)
          & (haddr_i[31:5] == 27'h0) & (haddr_i[1:0] == 2'h0);
        aph_r.wr <= hwrite_i;
        aph_r.idx <= haddr_i[4:2];
        hreadyout_o <= ~(hsel_i & (htrans_i == tbc_pkg::HTRANS_NONSEQ) & ~hwrite_i);
      end
      else
      begin
        hreadyout_o <= 1'b1;
        hrdata_o <= aph_r.act ? {24'h000000, read_reg(aph_r.idx)} : 32'h0000_0000;
      end
    end
  end

  assign wr_en = aph_r.act & aph_r.wr & hreadyout_o;
  assign wdata = hwdata_i[7:0];
  // ----------------------------------------
  // Mode decode and count enable
  // ----------------------------------------
  assign baud_mode = ctrl_r.rx_sel | ctrl_r.tx_sel;
  assign clkout_mode = mode_r[tbc_pkg::BIT_CLK_OE] & ~ctrl_r.ct_sel;
  // Fast state-time rate in baud or clock-out mode
  assign inc = ctrl_r.run & (ctrl_r.ct_sel ? cnt_fall
    : ((baud_mode | clkout_mode) ? state_tick : mach_tick));
  assign ovf = inc & (count_r == tbc_pkg::COUNT_MAX);
  assign edge_ev = edge_fall & ctrl_r.edge_en;
  assign auto_rl = baud_mode | ~ctrl_r.cap_sel;
  // Edge reload only outside baud mode
  assign reload_now = (ovf & auto_rl) | (edge_ev & ~baud_mode & ~ctrl_r.cap_sel);
  assign capture_now = edge_ev & ctrl_r.cap_sel & ~baud_mode;
  // ----------------------------------------
  // Counter
  // ----------------------------------------
  // Software byte write wins over counting
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      count_r <= tbc_pkg::RST_WORD;
    end
    else if (wr_hit(tbc_pkg::IDX_COUNT_LOW))
    begin
      count_r[7:0] <= wdata;
    end
    else if (wr_hit(tbc_pkg::IDX_COUNT_HIGH))
    begin
      count_r[15:8] <= wdata;
    end
    else if (reload_now)
    begin
      count_r <= reload_r;
    end
    else if (inc)
    begin
      count_r <= count_r + 16'h0001;
    end
  end
  // Reload bytes, loaded by capture outside baud mode
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      reload_r <= tbc_pkg::RST_WORD;
    end
    else if (wr_hit(tbc_pkg::IDX_RELOAD_LOW))
    begin
      reload_r[7:0] <= wdata;
    end
    else if (wr_hit(tbc_pkg::IDX_RELOAD_HIGH))
    begin
      reload_r[15:8] <= wdata;
    end
    else if (capture_now)
    begin
      reload_r <= count_r;
    end
  end

  // ----------------------------------------
  // Control byte and flags
  // ----------------------------------------
  // Hardware set wins over software clear
  always_comb
  begin
    ctrl_nxt = wr_hit(tbc_pkg::IDX_MAIN_CTRL) ? wdata : ctrl_r;
    if (ovf & ~baud_mode & ~clkout_mode)
    begin
      ctrl_nxt.ovf = 1'b1;
    end
    if (edge_ev)
    begin
      ctrl_nxt.ext_flag = 1'b1;
    end
  end
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      ctrl_r <= tbc_pkg::RST_BYTE;
      mode_r <= tbc_pkg::RST_BYTE;
      ie_r <= tbc_pkg::RST_BYTE;
      pin_r <= tbc_pkg::RST_PIN_CTRL;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      if (wr_hit(tbc_pkg::IDX_MODE_CTRL))
      begin
        mode_r <= wdata & tbc_pkg::MODE_WR_MASK;
      end
      if (wr_hit(tbc_pkg::IDX_IRQ_ENABLE))
      begin
        ie_r <= wdata & tbc_pkg::IE_WR_MASK;
      end
      if (wr_hit(tbc_pkg::IDX_PIN_CTRL))
      begin
        pin_r <= wdata & tbc_pkg::PIN_WR_MASK;
      end
    end
  end

  // ----------------------------------------
  // Baud bit ticks
  // ----------------------------------------
  // Sixteen overflows per serial bit
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      baud_div_r <= 4'h0;
      rx_bit_tick_o <= 1'b0;
      tx_bit_tick_o <= 1'b0;
    end
    else
    begin
      if (ovf & baud_mode)
      begin
        baud_div_r <= baud_div_r + 4'h1;
      end
      rx_bit_tick_o <= ovf & (baud_div_r == tbc_pkg::BAUD_DIV_LAST) & ctrl_r.rx_sel;
      tx_bit_tick_o <= ovf & (baud_div_r == tbc_pkg::BAUD_DIV_LAST) & ctrl_r.tx_sel;
    end
  end

  // ----------------------------------------
  // Clock-out pin
  // ----------------------------------------
  // Wave toggles on each overflow; else quasi I/O latch
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      clk_wave_r <= 1'b1;
      clock_out_pin_o <= 1'b1;
      clock_out_pin_oe_o <= 1'b0;
    end
    else
    begin
      if (ovf & clkout_mode)
      begin
        clk_wave_r <= ~clk_wave_r;
      end
      clock_out_pin_o <= clkout_mode ? clk_wave_r : pin_r[tbc_pkg::BIT_PIN_LATCH];
      clock_out_pin_oe_o <= clkout_mode | ~pin_r[tbc_pkg::BIT_PIN_LATCH];
    end
  end

  // ----------------------------------------
  // Interrupt enables
  // ----------------------------------------
  // Timer request from flags as they are set
  assign src = {ctrl_nxt.ovf | ctrl_nxt.ext_flag, serial_req_i, timer1_req_i,
    ext1_req_i, timer0_req_i, ext0_req_i};
  // Per-source gating by global and own enable
  generate
    for (genvar g = 0; g < tbc_pkg::NUM_SRC; g++)
    begin : g_src
      always_ff @(posedge core_clk_i)
      begin
        if (!rst_n_i)
        begin
          irq_req_o[g] <= 1'b0;
        end
        else
        begin
          irq_req_o[g] <= ie_r[tbc_pkg::BIT_GLOBAL_EN] & ie_r[g] & src[g];
        end
      end
    end
  endgenerate
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_baud_no_flag: assert property (ovf & baud_mode & ~wr_hit(tbc_pkg::IDX_MAIN_CTRL)
    |=> ctrl_r.ovf == $past(ctrl_r.ovf)) else $error("baud rollover changed overflow flag");
  a_roll_reload: assert property (ovf & auto_rl & ~wr_hit(tbc_pkg::IDX_COUNT_LOW)
    & ~wr_hit(tbc_pkg::IDX_COUNT_HIGH) |=> count_r == $past(reload_r)) else $error("rollover missed reload");
  a_state_rate: assert property (ctrl_r.run & baud_mode & ~ctrl_r.ct_sel & ~state_tick
    |-> ~inc) else $error("baud timer counted off state tick");
  a_mach_rate: assert property (inc & ~ctrl_r.ct_sel & ~baud_mode & ~clkout_mode
    |-> mach_tick) else $error("plain timer counted off machine tick");
  a_edge_no_reload: assert property (baud_mode & edge_ev & ~ovf
    |-> ~reload_now ##1 ctrl_r.ext_flag) else $error("baud edge reloaded or missed flag");
  a_clkout_toggle: assert property (clkout_mode & ovf |=> clk_wave_r != $past(clk_wave_r)
    ##1 clock_out_pin_o == $past(clk_wave_r)) else $error("clock-out wave did not toggle");
  a_clkout_no_irq: assert property (clkout_mode & ovf & ~wr_hit(tbc_pkg::IDX_MAIN_CTRL)
    |=> ctrl_r.ovf == $past(ctrl_r.ovf)) else $error("clock-out rollover set overflow flag");
  a_bit_tick: assert property (ovf & (baud_div_r == tbc_pkg::BAUD_DIV_LAST)
    |=> rx_bit_tick_o == $past(ctrl_r.rx_sel) && tx_bit_tick_o == $past(ctrl_r.tx_sel))
    else $error("bit tick not at sixteenth overflow");
  a_flag_hold: assert property (ctrl_r.ovf & ~wr_hit(tbc_pkg::IDX_MAIN_CTRL)
    |=> ctrl_r.ovf) else $error("overflow flag cleared by hardware");
  a_global_gate: assert property (~ie_r[tbc_pkg::BIT_GLOBAL_EN] |=> irq_req_o == 6'h00)
    else $error("request passed with global enable low");
  a_t2_req_or: assert property (ie_r[tbc_pkg::BIT_GLOBAL_EN] & ie_r[tbc_pkg::SRC_TIMER2]
    |=> irq_req_o[tbc_pkg::SRC_TIMER2] == ($past(ctrl_nxt.ovf) | $past(ctrl_nxt.ext_flag)))
    else $error("timer request is not flag OR");
  a_ie_reserved: assert property (ie_r[6] == 1'b0) else $error("reserved enable bit set");
  c_baud_reload: cover property (baud_mode & ovf);
  c_clkout_wave: cover property (clkout_mode & ovf ##[1:300] clkout_mode & ovf);
  c_t2_irq: cover property ($rose(irq_req_o[tbc_pkg::SRC_TIMER2]));
  c_capture: cover property (capture_now);

endmodule // tbc_timer2

// [core/tbc_pkg.sv]
// Constants and types for the third timer with baud, clock-out and interrupt enable
package tbc_pkg;

  // ----------------------------------------
  // Register indexes (byte offset is four times the index)
  // ----------------------------------------
  localparam logic [2:0] IDX_MAIN_CTRL = 3'h0;
  localparam logic [2:0] IDX_MODE_CTRL = 3'h1;
  localparam logic [2:0] IDX_COUNT_LOW = 3'h2;
  localparam logic [2:0] IDX_COUNT_HIGH = 3'h3;
  localparam logic [2:0] IDX_RELOAD_LOW = 3'h4;
  localparam logic [2:0] IDX_RELOAD_HIGH = 3'h5;
  localparam logic [2:0] IDX_IRQ_ENABLE = 3'h6;
  localparam logic [2:0] IDX_PIN_CTRL = 3'h7;

  // ----------------------------------------
  // Field positions and masks
  // ----------------------------------------
  localparam int BIT_CLK_OE = 1;
  localparam int BIT_GLOBAL_EN = 7;
  localparam int BIT_PIN_LATCH = 0;
  localparam int BIT_PIN_LEVEL = 1;
  localparam int SRC_TIMER2 = 5;
  localparam int NUM_SRC = 6;
  localparam logic [7:0] MODE_WR_MASK = 8'h03;
  localparam logic [7:0] IE_WR_MASK = 8'hBF;
  localparam logic [7:0] PIN_WR_MASK = 8'h01;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_PIN_CTRL = 8'h01;
  localparam logic [15:0] RST_WORD = 16'h0000;

  // ----------------------------------------
  // Oscillator periods per tick, count limits and bus codes
  // ----------------------------------------
  localparam logic [3:0] OSC_PER_MACHINE = 4'hC;
  localparam logic [3:0] OSC_PER_STATE = 4'h2;
  localparam logic [3:0] BAUD_DIV_LAST = 4'hF;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // Main control byte, bit 7 first
  typedef struct packed {
    logic ovf;
    logic ext_flag;
    logic rx_sel;
    logic tx_sel;
    logic edge_en;
    logic run;
    logic ct_sel;
    logic cap_sel;
  } tbc_ctrl_type;

  // Captured bus address phase
  typedef struct packed {
    logic act;
    logic wr;
    logic [2:0] idx;
  } tbc_aph_type;

endpackage

// [core/tbc_prescale.sv]
// Oscillator prescaler giving state-time and machine-cycle ticks
`timescale 1ns/10ps
module tbc_prescale (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  output logic state_tick_o,
  output logic mach_tick_o
);
  logic [3:0] div_r;

  // ----------------------------------------
  // Divider and tick pulses
  // ----------------------------------------
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      div_r <= 4'h0;
      state_tick_o <= 1'b0;
      mach_tick_o <= 1'b0;
    end
    else
    begin
      div_r <= (div_r == tbc_pkg::OSC_PER_MACHINE - 4'h1) ? 4'h0 : div_r + 4'h1;
      state_tick_o <= (div_r % tbc_pkg::OSC_PER_STATE) == 4'h1;
      mach_tick_o <= div_r == tbc_pkg::OSC_PER_MACHINE - 4'h1;
    end
  end
endmodule // tbc_prescale

// [core/tbc_fall_detect.sv]
// Falling-edge detector sampling a pin once per machine cycle
`timescale 1ns/10ps
module tbc_fall_detect (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic sample_i,
  input wire logic pin_i,
  output logic fall_o
);
  logic last_r;

  // ----------------------------------------
  // High in one sample, low in the next
  // ----------------------------------------
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      last_r <= 1'b1;
      fall_o <= 1'b0;
    end
    else
    begin
      fall_o <= sample_i & last_r & ~pin_i;
      if (sample_i)
      begin
        last_r <= pin_i;
      end
    end
  end
endmodule // tbc_fall_detect

// [dv/tbc_serial_model.sv]
// Far-side model: serial port bit counter and the shared pin with its pull-up
`timescale 1ns/10ps
module tbc_serial_model (
  input wire logic core_clk_i,
  input wire logic rx_bit_tick_i,
  input wire logic tx_bit_tick_i,
  input wire logic pin_drv_i,
  input wire logic pin_oe_i,
  input wire logic ext_low_i,
  output logic pin_level_o,
  output logic [15:0] rx_bits_o,
  output logic [15:0] tx_bits_o
);
  // Pull-up holds the pin high unless the timer or an outside part pulls it
  assign pin_level_o = pin_oe_i ? pin_drv_i : !ext_low_i;
  // One bit shifted per tick in each direction
  initial
  begin
    rx_bits_o = 16'h0000;
    tx_bits_o = 16'h0000;
  end
  always @(posedge core_clk_i)
  begin
    if (rx_bit_tick_i === 1'b1)
      rx_bits_o <= rx_bits_o + 16'h0001;
    if (tx_bit_tick_i === 1'b1)
      tx_bits_o <= tx_bits_o + 16'h0001;
  end
endmodule // tbc_serial_model

// [dv/tb.sv]
// Self-checking bench for the third timer: registers, gating, baud and clock-out
`timescale 1ns/10ps
module tb;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  typedef struct packed {logic [7:0] a; logic [7:0] wd; logic [7:0] er; logic [5:0] eq;} tbc_row_type;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h00000000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h00000000;
  logic edge_pin = 1'b1;
  logic ext_low = 1'b0;
  logic [4:0] reqs = 5'h00;
  logic [31:0] hrdata_o;
  logic hreadyout_o, hresp_o, pin_o, pin_oe, pin_w, pin_q, rx_t, tx_t;
  logic [5:0] irq;
  logic [15:0] rx_bits, tx_bits, tb0;
  int mismatches = 0;
  int checks_done = 0;
  int n;
  wire [3:0] ev = {irq[5], pin_w ^ pin_q, tx_t, rx_t};
  tbc_row_type rows [15] = '{{8'h04, 8'hFF, 8'h03, 6'h00}, {8'h08, 8'h5A, 8'h5A, 6'h00},
    {8'h0C, 8'hC3, 8'hC3, 6'h00}, {8'h10, 8'h96, 8'h96, 6'h00}, {8'h14, 8'h69, 8'h69, 6'h00},
    {8'h20, 8'h55, 8'h00, 6'h00}, {8'h18, 8'h3F, 8'h3F, 6'h00}, {8'h18, 8'h80, 8'h80, 6'h00},
    {8'h18, 8'h81, 8'h81, 6'h01}, {8'h18, 8'h82, 8'h82, 6'h02}, {8'h18, 8'h84, 8'h84, 6'h04},
    {8'h18, 8'h88, 8'h88, 6'h08}, {8'h18, 8'h90, 8'h90, 6'h10}, {8'h18, 8'hA0, 8'hA0, 6'h20},
    {8'h18, 8'hBF, 8'hBF, 6'h3F}};
  // Clock and pin history
  always #5 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) pin_q <= pin_w;
  tbc_timer2 u_tbc_timer2 (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(tbc_pkg::HSIZE_WORD), .hwdata_i(hwdata),
    .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .edge_input_pin_i(edge_pin), .clock_out_pin_i(pin_w), .clock_out_pin_o(pin_o),
    .clock_out_pin_oe_o(pin_oe), .ext0_req_i(reqs[0]), .timer0_req_i(reqs[1]), .ext1_req_i(reqs[2]),
    .timer1_req_i(reqs[3]), .serial_req_i(reqs[4]), .irq_req_o(irq), .rx_bit_tick_o(rx_t),
    .tx_bit_tick_o(tx_t));
  tbc_serial_model u_tbc_serial_model (.core_clk_i(core_clk_i), .rx_bit_tick_i(rx_t),
    .tx_bit_tick_i(tx_t), .pin_drv_i(pin_o), .pin_oe_i(pin_oe), .ext_low_i(ext_low),
    .pin_level_o(pin_w), .rx_bits_o(rx_bits), .tx_bits_o(tx_bits));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict();
    if (mismatches == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Single word transfer; address phase held until ready, data phase likewise
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] wd, output logic [31:0] rd);
    int k;
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= tbc_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    k = 0;
    do
    begin
      @(posedge core_clk_i);
      k++;
    end
    while (hreadyout_o !== 1'b1 && k < 50);
    htrans <= 2'h0;
    hwdata <= {24'h000000, wd};
    do
    begin
      @(posedge core_clk_i);
      k++;
    end
    while (hreadyout_o !== 1'b1 && k < 100);
    rd = hrdata_o;
    if (k >= 100)
    begin
      mismatches++;
      print_verdict();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] x;
    bus(1'b0, a, 8'h00, x);
    check("read data", x, {24'h000000, e});
    check("bus response", {31'h0, hresp_o}, 32'h0);
  endtask
  // Bounded wait for one event line, returning the edges counted
  task automatic wait_ev(input int s, output int k);
    k = 0;
    do
    begin
      @(posedge core_clk_i);
      #1;
      k++;
    end
    while (ev[s] !== 1'b1 && k < 3000);
    if (ev[s] !== 1'b1)
    begin
      mismatches++;
      print_verdict();
    end
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    repeat (10) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    @(posedge core_clk_i);
    reqs <= 5'h1F;
    wr(8'h00, 8'h80);
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].wd);
      rd(rows[i].a, rows[i].er);
      check("irq lines", {26'h0, irq}, {26'h0, rows[i].eq});
    end
    // Edge flag alone requests, and stays until software clears it
    wr(8'h18, 8'hA0);
    wr(8'h00, 8'h40);
    rd(8'h00, 8'h40);
    check("edge request", {31'h0, irq[5]}, 32'h1);
    wr(8'h00, 8'h00);
    rd(8'h00, 8'h00);
    check("request cleared", {31'h0, irq[5]}, 32'h0);
    // Pin as plain output, clock-out switched off first
    wr(8'h04, 8'h00);
    wr(8'h1C, 8'h00);
    rd(8'h1C, 8'h00);
    check("pin drive", {30'h0, pin_oe, pin_w}, 32'h2);
    wr(8'h1C, 8'h01);
    // Plain timer: overflow every 16 machine cycles
    wr(8'h10, 8'hF0);
    wr(8'h14, 8'hFF);
    wr(8'h08, 8'hF0);
    wr(8'h0C, 8'hFF);
    wr(8'h00, 8'h04);
    wait_ev(3, n);
    wr(8'h00, 8'h04);
    wait_ev(3, n);
    check("timer period", n, 190);
    // Receive-only baud with capture select set
    wr(8'h00, 8'h00);
    tb0 = tx_bits;
    wr(8'h00, 8'h25);
    wait_ev(0, n);
    wait_ev(0, n);
    check("rx bit period", n, 512);
    rd(8'h00, 8'h25);
    check("baud request", {31'h0, irq[5]}, 32'h0);
    check("tx silent", {16'h0, tx_bits}, {16'h0, tb0});
    check("rx bits", {16'h0, rx_bits}, 32'h2);
    // Transmit baud and clock-out together, edge pin falls mid-run
    wr(8'h00, 8'h00);
    wr(8'h04, 8'h02);
    wr(8'h00, 8'h1C);
    wait_ev(1, n);
    edge_pin <= 1'b0;
    wait_ev(1, n);
    check("tx bit period", n, 512);
    wait_ev(2, n);
    wait_ev(2, n);
    check("clock half period", n, 32);
    check("clock enable", {31'h0, pin_oe}, 32'h1);
    rd(8'h00, 8'h5C);
    check("edge request", {31'h0, irq[5]}, 32'h1);
    // Counting falls of the shared pin
    wr(8'h00, 8'h00);
    edge_pin <= 1'b1;
    wr(8'h04, 8'h00);
    wr(8'h08, 8'h00);
    wr(8'h0C, 8'h00);
    wr(8'h00, 8'h06);
    // Let the count input be sampled high before the first fall
    repeat (24) @(posedge core_clk_i);
    repeat (3)
    begin
      ext_low <= 1'b1;
      repeat (30) @(posedge core_clk_i);
      ext_low <= 1'b0;
      repeat (30) @(posedge core_clk_i);
    end
    wr(8'h00, 8'h00);
    rd(8'h08, 8'h03);
    // Reset in mid-run restores every register
    wr(8'h00, 8'h34);
    rst_n_i <= 1'b0;
    repeat (10) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    @(posedge core_clk_i);
    for (int a = 0; a < 32; a += 4)
      rd(a[7:0], (a == 28) ? 8'h03 : 8'h00);
    check("irq after reset", {26'h0, irq}, 32'h0);
    print_verdict();
  end
endmodule // tb
